// ### rtl/timer8_compare.sv
// One compare register with its software-side buffer
`timescale 1ns/1ps
module timer8_compare (
	input wire logic clk,
	input wire logic rst,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	input wire logic buffered,
	input wire logic load,
	output logic [7:0] active_value,
	output logic [7:0] buffer_value
);
	import timer8_pkg::*;

	typedef struct packed {
		logic [7:0] buf_val;
		logic [7:0] act_val;
	} cmp_state_t;

	cmp_state_t state_reg;
	cmp_state_t state_next;

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		if (cpu_wr) begin
			state_next.buf_val = cpu_wdata;
		end
		if (!buffered) begin
			state_next.act_val = state_next.buf_val;
		end else if (load) begin
			// Old buffer moves even if software writes in the same cycle
			state_next.act_val = state_reg.buf_val;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{buf_val: CMP_RST, act_val: CMP_RST};
		end else begin
			state_reg <= state_next;
		end
	end

	assign active_value = state_reg.act_val;
	assign buffer_value = state_reg.buf_val;

endmodule : timer8_compare

// ### rtl/timer8_pkg.sv
// Constants, register map and types shared by the 8-bit waveform timer
package timer8_pkg;

	// ==========================================================
	// Widths and counter limits
	localparam int DATA_W = 8;
	localparam int NUM_CHAN = 2;
	localparam int CHAN_A = 0;
	localparam int CHAN_B = 1;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_CMP_A = 8'h08;
	localparam logic [7:0] ADDR_CMP_B = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_PIN_DIR = 8'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_OUT_B_LSB = 4;
	localparam int CTRL_OUT_A_LSB = 6;
	localparam int CTRL_CLK_LSB = 8;
	localparam int CTRL_FORCE_A_BIT = 16;
	localparam int CTRL_FORCE_B_BIT = 17;
	localparam int FLAG_WRAP_BIT = 0;
	localparam int FLAG_MATCH_A_BIT = 1;
	localparam int FLAG_MATCH_B_BIT = 2;
	localparam int PIN_DIR_A_BIT = 0;
	localparam int PIN_DIR_B_BIT = 1;
	localparam int MODE_HIGH_BIT = 2;

	// ==========================================================
	// Reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [2:0] CLK_SEL_RST = 3'h0;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CMP_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ==========================================================
	// Waveform modes
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_PC_MAX = 3'h1;
	localparam logic [2:0] MODE_CLEAR_MATCH = 3'h2;
	localparam logic [2:0] MODE_FAST_MAX = 3'h3;
	localparam logic [2:0] MODE_PC_CMP = 3'h5;
	localparam logic [2:0] MODE_FAST_CMP = 3'h7;

	// Compare output modes
	localparam logic [1:0] OUT_OFF = 2'h0;
	localparam logic [1:0] OUT_TOGGLE = 2'h1;
	localparam logic [1:0] OUT_CLEAR = 2'h2;
	localparam logic [1:0] OUT_SET = 2'h3;

	// ==========================================================
	// Clock source selection and prescale masks
	localparam logic [2:0] CLK_STOP = 3'h0;
	localparam logic [2:0] CLK_DIV1 = 3'h1;
	localparam logic [2:0] CLK_DIV8 = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h3;
	localparam logic [2:0] CLK_DIV256 = 3'h4;
	localparam logic [2:0] CLK_DIV1024 = 3'h5;
	localparam logic [2:0] CLK_EXT_FALL = 3'h6;
	localparam logic [2:0] CLK_EXT_RISE = 3'h7;
	localparam logic [9:0] MASK_DIV8 = 10'h007;
	localparam logic [9:0] MASK_DIV64 = 10'h03F;
	localparam logic [9:0] MASK_DIV256 = 10'h0FF;
	localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
	localparam logic [9:0] PRESC_RST = 10'h000;

	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} count_dir_t;

endpackage : timer8_pkg

// ### rtl/timer8_prescaler.sv
// Timer clock enable generator: stop, divided I/O clock or external edge
`timescale 1ns/1ps
module timer8_prescaler (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] clock_source_sel,
	input wire logic ext_clk_in,
	output logic tick
);
	import timer8_pkg::*;

	typedef struct packed {
		logic [9:0] presc;
		logic ext_prev;
		logic tick;
	} presc_state_t;

	presc_state_t state_reg;
	presc_state_t state_next;

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		state_next.presc = 10'(state_reg.presc + 10'h001);
		state_next.ext_prev = ext_clk_in;
		case (clock_source_sel)
			CLK_STOP: state_next.tick = 1'b0;
			CLK_DIV1: state_next.tick = 1'b1;
			CLK_DIV8: state_next.tick = (state_reg.presc & MASK_DIV8) == MASK_DIV8;
			CLK_DIV64: state_next.tick = (state_reg.presc & MASK_DIV64) == MASK_DIV64;
			CLK_DIV256: state_next.tick = (state_reg.presc & MASK_DIV256) == MASK_DIV256;
			CLK_DIV1024: state_next.tick = state_reg.presc == MASK_DIV1024;
			CLK_EXT_FALL: state_next.tick = state_reg.ext_prev & ~ext_clk_in;
			CLK_EXT_RISE: state_next.tick = ~state_reg.ext_prev & ext_clk_in;
			default: state_next.tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{presc: PRESC_RST, ext_prev: 1'b0, tick: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick = state_reg.tick;

endmodule : timer8_prescaler

// ### rtl/timer8_waveform.sv
// 8-bit timer/counter with two compare channels, six waveform modes, APB slave
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module timer8_waveform (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clk_in,
	input wire logic irq_ack_wrap,
	input wire logic irq_ack_match_a,
	input wire logic irq_ack_match_b,
	output logic wrap_flag,
	output logic match_a_flag,
	output logic match_b_flag,
	output logic wave_out_a,
	output logic wave_out_a_oe,
	output logic wave_out_b,
	output logic wave_out_b_oe
);
	import timer8_pkg::*;

	typedef struct packed {
		logic [2:0] waveform_mode_sel;
		logic [NUM_CHAN-1:0][1:0] compare_out_mode;
		logic [2:0] clock_source_sel;
		logic [NUM_CHAN-1:0] pin_dir;
		logic [7:0] count_value;
		count_dir_t dir;
		logic blocked;
		logic wrap_flag;
		logic [NUM_CHAN-1:0] match_flag;
		logic [NUM_CHAN-1:0] wave_out;
		logic [NUM_CHAN-1:0] up_done;
		logic [NUM_CHAN-1:0] pin_out;
		logic [NUM_CHAN-1:0] pin_oe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} timer_state_t;

	timer_state_t state_reg;
	timer_state_t state_next;

	logic tick;
	logic [NUM_CHAN-1:0] cmp_wr;
	logic [NUM_CHAN-1:0][7:0] cmp_act;
	logic [NUM_CHAN-1:0][7:0] cmp_buf;
	logic is_fast;
	logic is_pc;
	logic is_pwm;
	logic cmp_load;
	logic [7:0] top_value;
	logic wr_en;

	// ==========================================================
	// Timer clock enable
	timer8_prescaler u_prescaler (
		.clk(clk),
		.rst(rst),
		.clock_source_sel(state_reg.clock_source_sel),
		.ext_clk_in(ext_clk_in),
		.tick(tick)
	);

	// ==========================================================
	// Mode decode shared with the compare channels
	always_comb begin
		is_fast = (state_reg.waveform_mode_sel == MODE_FAST_MAX) ||
			(state_reg.waveform_mode_sel == MODE_FAST_CMP);
		is_pc = (state_reg.waveform_mode_sel == MODE_PC_MAX) ||
			(state_reg.waveform_mode_sel == MODE_PC_CMP);
		is_pwm = is_fast | is_pc;
		if (is_pwm && state_reg.waveform_mode_sel[MODE_HIGH_BIT]) begin
			top_value = cmp_act[CHAN_A];
		end else begin
			top_value = CNT_MAX;
		end
		// Fast PWM loads as the counter leaves top for zero, phase-correct at top
		cmp_load = tick && (state_reg.count_value == top_value) &&
			(is_fast || (is_pc && state_reg.dir == DIR_UP));
		wr_en = psel && penable && pwrite && state_reg.pready;
	end

	// ==========================================================
	// Compare channels
	generate
		for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
			assign cmp_wr[ch] = wr_en &&
				(paddr == ((ch == CHAN_A) ? ADDR_CMP_A : ADDR_CMP_B));
			timer8_compare u_compare (
				.clk(clk),
				.rst(rst),
				.cpu_wr(cmp_wr[ch]),
				.cpu_wdata(pwdata[7:0]),
				.buffered(is_pwm),
				.load(cmp_load),
				.active_value(cmp_act[ch]),
				.buffer_value(cmp_buf[ch])
			);
		end
	endgenerate

	// ==========================================================
	// Next state
	always_comb begin
		logic apb_setup;
		logic addr_hit;
		logic [31:0] rdata;
		logic count_wr;
		logic ctrl_wr;
		logic flags_wr;
		logic at_top;
		logic at_bottom;
		logic up_slope;
		logic wrap_set;
		logic [NUM_CHAN-1:0] match;
		logic [NUM_CHAN-1:0] force_cmp;
		logic [NUM_CHAN-1:0] flag_clr;
		logic [1:0] om;
		logic tog_ok;

		state_next = state_reg;
		apb_setup = psel && !penable;
		count_wr = wr_en && (paddr == ADDR_COUNT);
		ctrl_wr = wr_en && (paddr == ADDR_CTRL);
		flags_wr = wr_en && (paddr == ADDR_FLAGS);
		at_top = state_reg.count_value == top_value;
		at_bottom = state_reg.count_value == CNT_BOTTOM;
		up_slope = (state_reg.dir == DIR_UP) || at_bottom;
		wrap_set = 1'b0;
		force_cmp = '0;
		match = '0;
		flag_clr = '0;
		om = OUT_OFF;
		tog_ok = 1'b0;

		// ------------------------------------------------------
		// Register decode and read data, captured in the setup phase
		addr_hit = 1'b1;
		rdata = RDATA_RST;
		case (paddr)
			ADDR_CTRL: begin
				rdata[CTRL_MODE_LSB +: 3] = state_reg.waveform_mode_sel;
				rdata[CTRL_OUT_B_LSB +: 2] = state_reg.compare_out_mode[CHAN_B];
				rdata[CTRL_OUT_A_LSB +: 2] = state_reg.compare_out_mode[CHAN_A];
				rdata[CTRL_CLK_LSB +: 3] = state_reg.clock_source_sel;
			end
			ADDR_COUNT: rdata[7:0] = state_reg.count_value;
			ADDR_CMP_A: rdata[7:0] = cmp_buf[CHAN_A];
			ADDR_CMP_B: rdata[7:0] = cmp_buf[CHAN_B];
			ADDR_FLAGS: begin
				rdata[FLAG_WRAP_BIT] = state_reg.wrap_flag;
				rdata[FLAG_MATCH_A_BIT] = state_reg.match_flag[CHAN_A];
				rdata[FLAG_MATCH_B_BIT] = state_reg.match_flag[CHAN_B];
			end
			ADDR_PIN_DIR: rdata[PIN_DIR_B_BIT:PIN_DIR_A_BIT] = state_reg.pin_dir;
			default: addr_hit = 1'b0;
		endcase
		state_next.pready = apb_setup;
		state_next.pslverr = apb_setup && !addr_hit;
		if (apb_setup) begin
			state_next.prdata = rdata;
		end

		// ------------------------------------------------------
		// Control writes
		if (ctrl_wr) begin
			state_next.waveform_mode_sel = pwdata[CTRL_MODE_LSB +: 3];
			state_next.compare_out_mode[CHAN_B] = pwdata[CTRL_OUT_B_LSB +: 2];
			state_next.compare_out_mode[CHAN_A] = pwdata[CTRL_OUT_A_LSB +: 2];
			state_next.clock_source_sel = pwdata[CTRL_CLK_LSB +: 3];
			// Force strobes act only outside PWM and never touch flags or count
			force_cmp[CHAN_A] = pwdata[CTRL_FORCE_A_BIT] && !is_pwm;
			force_cmp[CHAN_B] = pwdata[CTRL_FORCE_B_BIT] && !is_pwm;
		end
		if (wr_en && (paddr == ADDR_PIN_DIR)) begin
			state_next.pin_dir = pwdata[PIN_DIR_B_BIT:PIN_DIR_A_BIT];
		end

		// ------------------------------------------------------
		// Compare matches, suppressed for one tick after a counter write
		for (int i = 0; i < NUM_CHAN; i++) begin
			match[i] = tick && !state_reg.blocked &&
				(state_reg.count_value == cmp_act[i]);
		end

		// ------------------------------------------------------
		// Counting sequence; the waveform mode steers it, compare A sets top or the clear point
		if (count_wr) begin
			state_next.count_value = pwdata[7:0];
			state_next.blocked = 1'b1;
		end else if (tick) begin
			state_next.blocked = 1'b0;
			if (is_fast) begin
				state_next.dir = DIR_UP;
				if (at_top) begin
					state_next.count_value = CNT_BOTTOM;
					wrap_set = 1'b1;
				end else begin
					state_next.count_value = 8'(state_reg.count_value + CNT_ONE);
				end
			end else if (is_pc) begin
				wrap_set = at_bottom;
				if (state_reg.dir == DIR_UP) begin
					if (at_top) begin
						state_next.dir = DIR_DOWN;
						state_next.count_value = 8'(state_reg.count_value - CNT_ONE);
					end else begin
						state_next.count_value = 8'(state_reg.count_value + CNT_ONE);
					end
				end else begin
					if (at_bottom) begin
						state_next.dir = DIR_UP;
						state_next.count_value = CNT_ONE;
					end else begin
						state_next.count_value = 8'(state_reg.count_value - CNT_ONE);
					end
				end
			end else begin
				state_next.dir = DIR_UP;
				// Unused mode codes count like normal mode
				wrap_set = state_reg.count_value == CNT_MAX;
				if ((state_reg.waveform_mode_sel == MODE_CLEAR_MATCH) && match[CHAN_A]) begin
					state_next.count_value = CNT_BOTTOM;
				end else begin
					state_next.count_value = 8'(state_reg.count_value + CNT_ONE);
				end
			end
		end

		// ------------------------------------------------------
		// Waveform outputs per channel
		for (int i = 0; i < NUM_CHAN; i++) begin
			om = state_reg.compare_out_mode[i];
			tog_ok = (i == CHAN_A) && state_reg.waveform_mode_sel[MODE_HIGH_BIT];
			if (!is_pwm) begin
				if (match[i] || force_cmp[i]) begin
					case (om)
						OUT_TOGGLE: state_next.wave_out[i] = !state_reg.wave_out[i];
						OUT_CLEAR: state_next.wave_out[i] = 1'b0;
						OUT_SET: state_next.wave_out[i] = 1'b1;
						default: state_next.wave_out[i] = state_reg.wave_out[i];
					endcase
				end
			end else if (om[1]) begin
				if (is_fast) begin
					// Leaving top wins, so compare at top holds a steady level
					if (tick && at_top) begin
						state_next.wave_out[i] = !om[0];
					end else if (match[i]) begin
						state_next.wave_out[i] = om[0];
					end
				end else begin
					if (tick && at_top && state_reg.dir == DIR_UP) begin
						if (cmp_buf[i] == top_value) begin
							state_next.wave_out[i] = !om[0];
						end else if (!state_reg.up_done[i]) begin
							state_next.wave_out[i] = om[0];
						end
					end else if (match[i]) begin
						state_next.wave_out[i] = up_slope ? om[0] : !om[0];
					end
				end
			end else if ((om == OUT_TOGGLE) && tog_ok && match[i]) begin
				state_next.wave_out[i] = !state_reg.wave_out[i];
			end
			// Remembers an up-slope match so a missed one can be made up at top
			if (tick && at_bottom) begin
				state_next.up_done[i] = 1'b0;
			end
			if (is_pc && match[i] && up_slope) begin
				state_next.up_done[i] = 1'b1;
			end
			state_next.pin_out[i] = state_next.wave_out[i];
			state_next.pin_oe[i] = state_next.pin_dir[i] &&
				(state_next.compare_out_mode[i] != OUT_OFF);
		end

		// ------------------------------------------------------
		// Flags: a set in the same cycle as a clear wins
		flag_clr[CHAN_A] = irq_ack_match_a || (flags_wr && pwdata[FLAG_MATCH_A_BIT]);
		flag_clr[CHAN_B] = irq_ack_match_b || (flags_wr && pwdata[FLAG_MATCH_B_BIT]);
		state_next.match_flag = (state_reg.match_flag & ~flag_clr) | match;
		state_next.wrap_flag = (state_reg.wrap_flag &&
			!(irq_ack_wrap || (flags_wr && pwdata[FLAG_WRAP_BIT]))) || wrap_set;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{
				waveform_mode_sel: MODE_RST,
				compare_out_mode: '0,
				clock_source_sel: CLK_SEL_RST,
				pin_dir: '0,
				count_value: COUNT_RST,
				dir: DIR_UP,
				blocked: 1'b0,
				wrap_flag: 1'b0,
				match_flag: '0,
				wave_out: '0,
				up_done: '0,
				pin_out: '0,
				pin_oe: '0,
				prdata: RDATA_RST,
				pready: 1'b0,
				pslverr: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign wrap_flag = state_reg.wrap_flag;
	assign match_a_flag = state_reg.match_flag[CHAN_A];
	assign match_b_flag = state_reg.match_flag[CHAN_B];
	assign wave_out_a = state_reg.pin_out[CHAN_A];
	assign wave_out_a_oe = state_reg.pin_oe[CHAN_A];
	assign wave_out_b = state_reg.pin_out[CHAN_B];
	assign wave_out_b_oe = state_reg.pin_oe[CHAN_B];

endmodule : timer8_waveform

// ### verification/timer8_waveform_bench.sv
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
module timer8_waveform_bench;
	import timer8_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic irq_ack_wrap = 1'h0;
	logic irq_ack_match_a = 1'h0;
	logic irq_ack_match_b = 1'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, e;
	logic wrap_flag, match_a_flag, match_b_flag;
	logic wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int per, hi;

	timer8_waveform dut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_clk_in(1'h0), .irq_ack_wrap(irq_ack_wrap), .irq_ack_match_a(irq_ack_match_a),
		.irq_ack_match_b(irq_ack_match_b), .wrap_flag(wrap_flag),
		.match_a_flag(match_a_flag),
		.match_b_flag(match_b_flag), .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
		.wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe)
	);

	// ==========================================================
	// Clock, timeout and verdict
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		// Longest scenario is a few thousand cycles, so this only trips on a hang
		if (cyc == 40000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	// ==========================================================
	// Shared helpers
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			num_errors++;
			$display("BAD %s expected %0h seen %0h", nm, x, g);
		end
	endtask : chk
	// Idle cycle after release keeps two transfers from driving psel in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		chk("pready", 1'h1, pready);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : xfer
	task automatic cfg(input logic [2:0] m, input logic [1:0] ob, input logic [1:0] oa,
		input logic [2:0] cs);
		xfer(1'h1, ADDR_CTRL, {21'h0, cs, oa, ob, 1'h0, m});
	endtask : cfg
	task automatic halt;
		cfg(MODE_NORMAL, OUT_OFF, OUT_OFF, CLK_STOP);
		xfer(1'h1, ADDR_COUNT, 32'h0);
		xfer(1'h1, ADDR_FLAGS, 32'h7);
		chk("flags", 32'h0, {match_b_flag, match_a_flag, wrap_flag});
	endtask : halt
	// Period and high time of one output, taken between two rising edges
	task automatic meas(input bit b);
		logic v, p;
		int n;
		n = 0;
		per = 0;
		hi = 0;
		v = b ? wave_out_b : wave_out_a;
		do begin
			p = v;
			@(posedge clk);
			v = b ? wave_out_b : wave_out_a;
			n++;
		end while (!(v && !p) && n < 3000);
		do begin
			p = v;
			@(posedge clk);
			v = b ? wave_out_b : wave_out_a;
			per++;
			hi += int'(p);
		end while (!(v && !p) && per < 3000);
	endtask : meas
	// High time of output B over one 64-cycle period, after two periods to settle
	task automatic level;
		hi = 0;
		repeat (128) @(posedge clk);
		repeat (64) begin
			@(posedge clk);
			hi += int'(wave_out_b);
		end
	endtask : level

	// ==========================================================
	// Scenarios
	task automatic t_normal;
		halt();
		xfer(1'h1, ADDR_CMP_A, 32'h3);
		xfer(1'h1, ADDR_COUNT, 32'hFE);
		repeat (4) @(posedge clk);
		xfer(1'h0, ADDR_COUNT, 32'h0);
		chk("count held", 32'hFE, q);
		cfg(MODE_NORMAL, OUT_OFF, OUT_TOGGLE, CLK_DIV1);
		repeat (4) @(posedge clk);
		chk("wrap", 1'h1, wrap_flag);
		meas(1'h0);
		chk("normal period", 32'h200, per);
		chk("normal high", 32'h100, hi);
		chk("match a", 1'h1, match_a_flag);
		irq_ack_match_a <= 1'h1;
		@(posedge clk);
		irq_ack_match_a <= 1'h0;
		@(posedge clk);
		chk("match a ack", 1'h0, match_a_flag);
		$display("normal done");
	endtask : t_normal
	task automatic t_clear_match;
		halt();
		xfer(1'h1, ADDR_CMP_A, 32'h3);
		xfer(1'h1, ADDR_PIN_DIR, 32'h1);
		cfg(MODE_CLEAR_MATCH, OUT_OFF, OUT_TOGGLE, CLK_DIV1);
		meas(1'h0);
		chk("clear period", 32'h8, per);
		chk("clear high", 32'h4, hi);
		chk("clear match", 1'h1, match_a_flag);
		chk("clear wrap", 1'h0, wrap_flag);
		chk("pin a drive", 1'h1, wave_out_a_oe);
		chk("pin b drive", 1'h0, wave_out_b_oe);
		xfer(1'h1, ADDR_CMP_A, 32'h0);
		meas(1'h0);
		chk("clear half rate", 32'h2, per);
		$display("clear match done");
	endtask : t_clear_match
	task automatic t_fast;
		halt();
		xfer(1'h1, ADDR_CMP_B, 32'h40);
		xfer(1'h1, ADDR_PIN_DIR, 32'h2);
		cfg(MODE_FAST_MAX, OUT_CLEAR, OUT_OFF, CLK_DIV1);
		meas(1'h1);
		chk("fast period", 32'h100, per);
		chk("fast high", 32'h41, hi);
		chk("fast wrap", 1'h1, wrap_flag);
		chk("fast match b", 1'h1, match_b_flag);
		irq_ack_wrap <= 1'h1;
		irq_ack_match_b <= 1'h1;
		@(posedge clk);
		irq_ack_wrap <= 1'h0;
		irq_ack_match_b <= 1'h0;
		@(posedge clk);
		chk("wrap ack", 1'h0, wrap_flag);
		chk("match b ack", 1'h0, match_b_flag);
		cfg(MODE_FAST_MAX, OUT_SET, OUT_OFF, CLK_DIV1);
		meas(1'h1);
		chk("fast inverted", 32'hBF, hi);
		xfer(1'h1, ADDR_CMP_B, 32'h0);
		cfg(MODE_FAST_MAX, OUT_CLEAR, OUT_OFF, CLK_DIV1);
		meas(1'h1);
		chk("fast spike", 32'h1, hi);
		$display("fast done");
	endtask : t_fast
	task automatic t_pc;
		halt();
		xfer(1'h1, ADDR_CMP_B, 32'h40);
		cfg(MODE_PC_MAX, OUT_CLEAR, OUT_OFF, CLK_DIV1);
		meas(1'h1);
		chk("pc period", 32'h1FE, per);
		chk("pc high", 32'h80, hi);
		chk("pc wrap", 1'h1, wrap_flag);
		cfg(MODE_PC_MAX, OUT_SET, OUT_OFF, CLK_DIV1);
		meas(1'h1);
		chk("pc inverted", 32'h17E, hi);
		halt();
		xfer(1'h1, ADDR_CMP_A, 32'h20);
		xfer(1'h1, ADDR_CMP_B, 32'h8);
		cfg(MODE_PC_CMP, OUT_CLEAR, OUT_OFF, CLK_DIV1);
		meas(1'h1);
		chk("pc top period", 32'h40, per);
		chk("pc top high", 32'h10, hi);
		xfer(1'h1, ADDR_CMP_B, 32'h0);
		level();
		chk("pc floor", 32'h0, hi);
		xfer(1'h1, ADDR_CMP_B, 32'h20);
		level();
		chk("pc ceiling", 32'h40, hi);
		$display("pc done");
	endtask : t_pc
	task automatic t_top;
		logic b0;
		halt();
		xfer(1'h1, ADDR_CMP_A, 32'h9);
		xfer(1'h1, ADDR_CMP_B, 32'h2);
		cfg(MODE_FAST_CMP, OUT_TOGGLE, OUT_TOGGLE, CLK_DIV1);
		b0 = wave_out_b;
		meas(1'h0);
		chk("top toggle", 32'h14, per);
		chk("b no toggle", b0, wave_out_b);
		xfer(1'h1, ADDR_CMP_A, 32'h4);
		meas(1'h0);
		chk("top reload", 32'hA, per);
		$display("top done");
	endtask : t_top
	task automatic t_block;
		halt();
		xfer(1'h1, ADDR_CMP_A, 32'h5);
		xfer(1'h1, ADDR_COUNT, 32'h5);
		cfg(MODE_NORMAL, OUT_OFF, OUT_OFF, CLK_DIV1);
		cfg(MODE_NORMAL, OUT_OFF, OUT_OFF, CLK_STOP);
		chk("match blocked", 1'h0, match_a_flag);
		xfer(1'h0, 8'h18, 32'h0);
		chk("unmapped err", 1'h1, e);
		chk("unmapped data", 32'h0, q);
		$display("block done");
	endtask : t_block

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_normal();
		t_clear_match();
		t_fast();
		t_pc();
		t_top();
		t_block();
		end_of_test();
	end
endmodule : timer8_waveform_bench

// ### verification/timer8_waveform_monitor.sv
// Checker on the waveform timer top ports, bound into the design
`timescale 1ns/1ps
module timer8_waveform_monitor (
	input logic clk,
	input logic rst,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic ext_clk_in,
	input logic irq_ack_wrap,
	input logic irq_ack_match_a,
	input logic irq_ack_match_b,
	input logic wrap_flag,
	input logic match_a_flag,
	input logic match_b_flag,
	input logic wave_out_a,
	input logic wave_out_a_oe,
	input logic wave_out_b,
	input logic wave_out_b_oe
);
	import timer8_pkg::*;
	logic done;
	logic clr;
	logic cfg_wr;
	logic bad_addr;
	// ==========================================================
	// Bus decode
	assign done = psel && penable && pready;
	assign clr = done && pwrite && paddr == ADDR_FLAGS;
	assign cfg_wr = done && pwrite && (paddr == ADDR_CTRL || paddr == ADDR_PIN_DIR);
	assign bad_addr = !(paddr inside {ADDR_CTRL, ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B,
		ADDR_FLAGS, ADDR_PIN_DIR});
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Assertions
	a_ready_first: assert property ($rose(penable) && psel |-> pready)
		else $error("no ready in first access cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_decode: assert property (pready |-> pslverr == bad_addr)
		else $error("error response does not follow address");
	a_err_zero_data: assert property (pslverr |-> prdata == 32'h0)
		else $error("read data not zero on error");
	a_wrap_sticky: assert property (
		wrap_flag && !irq_ack_wrap && !(clr && pwdata[FLAG_WRAP_BIT]) |=> wrap_flag)
		else $error("wrap flag dropped by itself");
	a_match_a_sticky: assert property (
		match_a_flag && !irq_ack_match_a && !(clr && pwdata[FLAG_MATCH_A_BIT]) |=> match_a_flag)
		else $error("match a flag dropped by itself");
	a_match_b_sticky: assert property (
		match_b_flag && !irq_ack_match_b && !(clr && pwdata[FLAG_MATCH_B_BIT]) |=> match_b_flag)
		else $error("match b flag dropped by itself");
	a_drive_by_config: assert property (
		$changed({wave_out_a_oe, wave_out_b_oe}) |-> $past(cfg_wr) || $past(cfg_wr, 2))
		else $error("pin drive changed without a config write");
	c_flag_clear: cover property (clr && wrap_flag);
	c_error: cover property (pslverr);
	c_wave_a: cover property ($rose(wave_out_a));
	c_wave_b: cover property ($rose(wave_out_b));
endmodule : timer8_waveform_monitor

bind timer8_waveform timer8_waveform_monitor mon (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_clk_in(ext_clk_in), .irq_ack_wrap(irq_ack_wrap), .irq_ack_match_a(irq_ack_match_a),
	.irq_ack_match_b(irq_ack_match_b), .wrap_flag(wrap_flag), .match_a_flag(match_a_flag),
	.match_b_flag(match_b_flag), .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
	.wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe)
);
